// ===== rtl/smbus_master_cfg_regs.vh
// register indices, field positions and reset values of the smbus master register bank
`ifndef SMBUS_MASTER_CFG_REGS_VH
`define SMBUS_MASTER_CFG_REGS_VH

// register indices; byte address is four times the index
`define IDX_PEC_ENABLE      8'hb1
`define IDX_FORMAT_DEV0_3   8'hb2
`define IDX_FORMAT_DEV4_7   8'hb3
`define IDX_MASTER_CFG      8'hb5
`define IDX_NO_ACK_STATUS   8'hb6
`define IDX_PKT_ERR_STATUS  8'hb7
`define IDX_TIMEOUT_STATUS  8'hb8
`define IDX_LIMIT_STATUS    8'hb9
`define IDX_NO_ACK_MASK     8'hbc
`define IDX_IRQ_STATUS      8'hd0
`define IDX_IRQ_MASK        8'hd1

// reset values
`define RST_PEC_ENABLE      8'h00
`define RST_FORMAT_DEV0_3   8'h03
`define RST_FORMAT_DEV4_7   8'h00
`define RST_MASTER_CFG      8'h08
`define RST_STATUS          8'h00
`define RST_NO_ACK_MASK     8'h00
`define RST_IRQ             4'h0

// master configuration fields
`define CFG_POLL_EN_BIT     0
`define CFG_HYS_MSB         4
`define CFG_HYS_LSB         1
`define CFG_R1_MOD_BIT      5
`define CFG_R2_MOD_BIT      6
`define CFG_HUB_BIT         7

// two-bit format codes, and the device whose code 3 is reserved
`define FMT_TWOS            2'h0
`define FMT_SPD             2'h1
`define FMT_BINARY          2'h2
`define FMT_CODE3           2'h3
`define DEV_RESERVED3       3'h4

// decoded format modes driven to the polling engine
`define MODE_TWOS           3'h0
`define MODE_SPD            3'h1
`define MODE_BINARY         3'h2
`define MODE_BLOCK          3'h3
`define MODE_LITERAL        3'h4
`define MODE_RESERVED       3'h5

// interrupt status bit positions
`define IRQ_NO_ACK          0
`define IRQ_PKT_ERR         1
`define IRQ_TIMEOUT         2
`define IRQ_LIMIT           3

`endif

// ===== rtl/smbus_master_cfg_status_regs.v
// configuration and status register bank of the smbus polling master, apb slave
//
// Added by the designer: the APB slave port.
`include "smbus_master_cfg_regs.vh"

// Summary of operation
// - polling runs only while enable bit set
// - devices 0-3 codes: twos, spd, binary, block
// - devices 5-7 code 11 means literal format
// - one hysteresis field applies to all readings
// - bit 5 copies remote1 to modules 0/1
// - bit 6 copies remote2 to modules 2/3
// - bit 7 sources modules from hub, overrides 5/6
// - no-acknowledge sets status bit at device index
// - packet error sets status bit at device index
// - timeout sets status bit at device index
// - out-of-limit reading sets status bit at index
// - format regs reset 0x03/0x00, status 0x00
// - master configuration resets to 0x08
// - no-ack mask bit blocks that alert
// - packet error check only when enabled
module smbus_master_cfg_status_regs (
  // clock, reset, enable
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // poll results from the smbus engine
  input  wire        poll_done,
  input  wire [2:0]  poll_dev_idx,
  input  wire        poll_no_ack,
  input  wire        poll_pec_fail,
  input  wire        poll_timeout,
  input  wire [7:0]  poll_reading,
  input  wire [7:0]  high_limit,
  input  wire [7:0]  low_limit,
  // controls to the smbus engine
  output reg         master_poll_enable,
  output reg  [3:0]  polled_temp_hysteresis,
  output reg  [2:0]  cur_format_mode,
  output reg         cur_pec_enable,
  output reg         remote1_to_modules_01,
  output reg         remote2_to_modules_23,
  output reg         module_temp_from_hub,
  // interrupt
  output reg         irq
);

  // software registers
  reg [7:0] pec_enable_reg;
  reg [7:0] temp_format_dev0_3_reg;
  reg [7:0] temp_format_dev4_7_reg;
  reg [7:0] master_enable_hysteresis_dimm_source_reg;
  reg [7:0] no_ack_status_reg;
  reg [7:0] packet_error_status_reg;
  reg [7:0] timeout_status_reg;
  reg [7:0] limit_violation_status_reg;
  reg [7:0] no_ack_mask_reg;
  reg [3:0] irq_status_reg;
  reg [3:0] irq_mask_reg;
  reg [7:0] limit_active_reg;

  // decoded format mode of one device
  function [2:0] format_mode;
    input [2:0] dev;
    input [7:0] lo_bank;
    input [7:0] hi_bank;
    reg   [1:0] code;
    begin
      code = dev[2] ? hi_bank[{dev[1:0], 1'b0} +: 2] : lo_bank[{dev[1:0], 1'b0} +: 2];
      if (code != `FMT_CODE3)
        format_mode = {1'b0, code};
      else if (!dev[2])
        format_mode = `MODE_BLOCK;
      else if (dev == `DEV_RESERVED3)
        format_mode = `MODE_RESERVED;
      else
        format_mode = `MODE_LITERAL;
    end
  endfunction

  // maps a reading onto an unsigned scale; twos complement is offset by flipping the sign
  function [7:0] biased;
    input [7:0] value;
    input       is_signed;
    begin
      biased = is_signed ? {~value[7], value[6:0]} : value;
    end
  endfunction

  // apb decode
  wire        setup_phase = psel & ~penable;
  wire        access_done = psel & penable & pready;
  wire [9:0]  word_idx    = paddr[11:2];
  wire        wr_done     = access_done & pwrite & ~pslverr;
  wire        rd_done     = access_done & ~pwrite & ~pslverr;
  wire [9:0]  idx_q       = word_idx;

  // unmapped address detection, reused for decode of the current request
  function mapped;
    input [9:0] idx;
    begin
      if (idx == {2'b00, `IDX_PEC_ENABLE})
        mapped = 1'b1;
      else if (idx == {2'b00, `IDX_FORMAT_DEV0_3})
        mapped = 1'b1;
      else if (idx == {2'b00, `IDX_FORMAT_DEV4_7})
        mapped = 1'b1;
      else if (idx == {2'b00, `IDX_MASTER_CFG})
        mapped = 1'b1;
      else if ((idx >= {2'b00, `IDX_NO_ACK_STATUS}) && (idx <= {2'b00, `IDX_LIMIT_STATUS}))
        mapped = 1'b1;
      else if (idx == {2'b00, `IDX_NO_ACK_MASK})
        mapped = 1'b1;
      else if (idx == {2'b00, `IDX_IRQ_STATUS})
        mapped = 1'b1;
      else if (idx == {2'b00, `IDX_IRQ_MASK})
        mapped = 1'b1;
      else
        mapped = 1'b0;
    end
  endfunction

  // read multiplexer
  reg [7:0] rd_value;
  always @*
  begin
    rd_value = 8'h00;
    if (idx_q == {2'b00, `IDX_PEC_ENABLE})
      rd_value = pec_enable_reg;
    else if (idx_q == {2'b00, `IDX_FORMAT_DEV0_3})
      rd_value = temp_format_dev0_3_reg;
    else if (idx_q == {2'b00, `IDX_FORMAT_DEV4_7})
      rd_value = temp_format_dev4_7_reg;
    else if (idx_q == {2'b00, `IDX_MASTER_CFG})
      rd_value = master_enable_hysteresis_dimm_source_reg;
    else if (idx_q == {2'b00, `IDX_NO_ACK_STATUS})
      rd_value = no_ack_status_reg;
    else if (idx_q == {2'b00, `IDX_PKT_ERR_STATUS})
      rd_value = packet_error_status_reg;
    else if (idx_q == {2'b00, `IDX_TIMEOUT_STATUS})
      rd_value = timeout_status_reg;
    else if (idx_q == {2'b00, `IDX_LIMIT_STATUS})
      rd_value = limit_violation_status_reg;
    else if (idx_q == {2'b00, `IDX_NO_ACK_MASK})
      rd_value = no_ack_mask_reg;
    else if (idx_q == {2'b00, `IDX_IRQ_STATUS})
      rd_value = {4'h0, irq_status_reg};
    else if (idx_q == {2'b00, `IDX_IRQ_MASK})
      rd_value = {4'h0, irq_mask_reg};
  end

  // poll result qualification; results are dropped while the master is disabled
  wire       poll_live    = poll_done & master_enable_hysteresis_dimm_source_reg[`CFG_POLL_EN_BIT];
  wire [7:0] dev_onehot   = 8'h01 << poll_dev_idx;
  wire [2:0] dev_mode     = format_mode(poll_dev_idx, temp_format_dev0_3_reg,
                                        temp_format_dev4_7_reg);
  wire       dev_pec_en   = pec_enable_reg[poll_dev_idx];
  wire       good_read    = poll_live & ~poll_no_ack & ~poll_timeout & ~(dev_pec_en & poll_pec_fail);
  wire [3:0] hys          = master_enable_hysteresis_dimm_source_reg[`CFG_HYS_MSB:`CFG_HYS_LSB];
  wire       is_signed    = (dev_mode == `MODE_TWOS);
  wire [7:0] rd_b         = biased(poll_reading, is_signed);
  wire [7:0] hi_b         = biased(high_limit, is_signed);
  wire [7:0] lo_b         = biased(low_limit, is_signed);
  wire       outside      = (rd_b > hi_b) | (rd_b < lo_b);
  // release only once the reading is back inside the window by the hysteresis margin
  wire       inside_hys   = ({1'b0, rd_b} + {5'h00, hys} <= {1'b0, hi_b}) &
                            ({1'b0, rd_b} >= {1'b0, lo_b} + {5'h00, hys});

  // per-class event vectors
  wire [7:0] ev_no_ack    = (poll_live & poll_no_ack)  ? dev_onehot : 8'h00;
  wire [7:0] ev_pkt_err   = (poll_live & poll_pec_fail & dev_pec_en & ~poll_no_ack)
                            ? dev_onehot : 8'h00;
  wire [7:0] ev_timeout   = (poll_live & poll_timeout) ? dev_onehot : 8'h00;
  wire [7:0] ev_limit     = (good_read & outside) ? dev_onehot : 8'h00;

  // clear-on-read strobes for each status register
  wire clr_no_ack  = rd_done & (idx_q == {2'b00, `IDX_NO_ACK_STATUS});
  wire clr_pkt_err = rd_done & (idx_q == {2'b00, `IDX_PKT_ERR_STATUS});
  wire clr_timeout = rd_done & (idx_q == {2'b00, `IDX_TIMEOUT_STATUS});
  wire clr_limit   = rd_done & (idx_q == {2'b00, `IDX_LIMIT_STATUS});

  // a read clears only the bits it reported; prdata was latched at the setup edge, so an
  // event landing between the setup and access edges is not lost by the clear
  wire [7:0] rd_seen      = prdata[7:0];
  wire [7:0] keep_no_ack  = clr_no_ack  ? ~rd_seen : 8'hff;
  wire [7:0] keep_pkt_err = clr_pkt_err ? ~rd_seen : 8'hff;
  wire [7:0] keep_timeout = clr_timeout ? ~rd_seen : 8'hff;
  wire [7:0] keep_limit   = clr_limit   ? ~rd_seen : 8'hff;

  // interrupt events; masked no-acks never reach the alert
  wire [3:0] irq_event;
  assign irq_event[`IRQ_NO_ACK]  = |(ev_no_ack & ~no_ack_mask_reg);
  assign irq_event[`IRQ_PKT_ERR] = |ev_pkt_err;
  assign irq_event[`IRQ_TIMEOUT] = |ev_timeout;
  assign irq_event[`IRQ_LIMIT]   = |ev_limit;

  wire [3:0] irq_w1c = (wr_done & (idx_q == {2'b00, `IDX_IRQ_STATUS})) ? pwdata[3:0] : 4'h0;
  wire [3:0] irq_status_next = (irq_status_reg & ~irq_w1c) | irq_event;

  // apb handshake: one wait-free access phase, answer registered in the setup cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      if (setup_phase)
      begin
        pready  <= 1'b1;
        pslverr <= ~mapped(word_idx);
        prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_value};
      end
      else if (access_done)
      begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // software-written configuration
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pec_enable_reg                           <= `RST_PEC_ENABLE;
      temp_format_dev0_3_reg                   <= `RST_FORMAT_DEV0_3;
      temp_format_dev4_7_reg                   <= `RST_FORMAT_DEV4_7;
      master_enable_hysteresis_dimm_source_reg <= `RST_MASTER_CFG;
      no_ack_mask_reg                          <= `RST_NO_ACK_MASK;
      irq_mask_reg                             <= `RST_IRQ;
    end
    else if (clk_en && wr_done)
    begin
      if (idx_q == {2'b00, `IDX_PEC_ENABLE})
        pec_enable_reg <= pwdata[7:0];
      else if (idx_q == {2'b00, `IDX_FORMAT_DEV0_3})
        temp_format_dev0_3_reg <= pwdata[7:0];
      else if (idx_q == {2'b00, `IDX_FORMAT_DEV4_7})
        temp_format_dev4_7_reg <= pwdata[7:0];
      else if (idx_q == {2'b00, `IDX_MASTER_CFG})
        master_enable_hysteresis_dimm_source_reg <= pwdata[7:0];
      else if (idx_q == {2'b00, `IDX_NO_ACK_MASK})
        no_ack_mask_reg <= pwdata[7:0];
      else if (idx_q == {2'b00, `IDX_IRQ_MASK})
        irq_mask_reg <= pwdata[3:0];
    end
  end

  // sticky status; a new event in the clearing read's cycle survives
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      no_ack_status_reg          <= `RST_STATUS;
      packet_error_status_reg    <= `RST_STATUS;
      timeout_status_reg         <= `RST_STATUS;
      limit_violation_status_reg <= `RST_STATUS;
      irq_status_reg             <= `RST_IRQ;
    end
    else if (clk_en)
    begin
      no_ack_status_reg          <= (no_ack_status_reg & keep_no_ack) | ev_no_ack;
      packet_error_status_reg    <= (packet_error_status_reg & keep_pkt_err) | ev_pkt_err;
      timeout_status_reg         <= (timeout_status_reg & keep_timeout) | ev_timeout;
      limit_violation_status_reg <= (limit_violation_status_reg & keep_limit) | ev_limit;
      irq_status_reg             <= irq_status_next;
    end
  end

  // limit tracking with hysteresis; a device stays out of limits until it recovers by the margin
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      limit_active_reg <= `RST_STATUS;
    else if (clk_en && good_read)
    begin
      if (outside)
        limit_active_reg <= limit_active_reg | dev_onehot;
      else if (inside_hys)
        limit_active_reg <= limit_active_reg & ~dev_onehot;
    end
  end

  // registered controls to the polling engine
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      master_poll_enable     <= 1'b0;
      polled_temp_hysteresis <= 4'h0;
      cur_format_mode        <= `MODE_TWOS;
      cur_pec_enable         <= 1'b0;
      remote1_to_modules_01  <= 1'b0;
      remote2_to_modules_23  <= 1'b0;
      module_temp_from_hub   <= 1'b0;
      irq                    <= 1'b0;
    end
    else if (clk_en)
    begin
      master_poll_enable     <= master_enable_hysteresis_dimm_source_reg[`CFG_POLL_EN_BIT];
      polled_temp_hysteresis <= hys;
      cur_format_mode        <= dev_mode;
      cur_pec_enable         <= dev_pec_en;
      // hub sourcing wins over both remote-diode copies
      remote1_to_modules_01  <= master_enable_hysteresis_dimm_source_reg[`CFG_R1_MOD_BIT] &
                                ~master_enable_hysteresis_dimm_source_reg[`CFG_HUB_BIT];
      remote2_to_modules_23  <= master_enable_hysteresis_dimm_source_reg[`CFG_R2_MOD_BIT] &
                                ~master_enable_hysteresis_dimm_source_reg[`CFG_HUB_BIT];
      module_temp_from_hub   <= master_enable_hysteresis_dimm_source_reg[`CFG_HUB_BIT];
      irq                    <= |(irq_status_next & irq_mask_reg);
    end
  end

endmodule

// ===== sim/sensor_poll_model.sv
// behavioural poll engine and remote sensors feeding the register bank
module sensor_poll_model (
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // command from the bench, fault is {timeout, pec fail, no ack}
  input  wire       go,
  input  wire [2:0] idx,
  input  wire [2:0] fault,
  input  wire [7:0] value,
  input  wire [7:0] hi_set,
  input  wire [7:0] lo_set,
  // result toward the bank
  output reg        poll_done,
  output reg  [2:0] poll_dev_idx,
  output reg  [2:0] poll_flags,
  output reg  [7:0] poll_reading,
  output wire [7:0] high_limit,
  output wire [7:0] low_limit
);
  timeunit 1ns;
  timeprecision 1ps;
  // limit window chosen by the bench per result, so signed and unsigned compares differ
  assign high_limit = hi_set;
  assign low_limit  = lo_set;
  // outside a result the index, flag and reading lines flip each cycle, so stale data is never trusted
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      poll_done    <= 1'b0;
      poll_dev_idx <= 3'h0;
      poll_flags   <= 3'h0;
      poll_reading <= 8'h00;
    end
    else
    begin
      poll_done    <= go;
      poll_dev_idx <= go ? idx : ~poll_dev_idx;
      poll_flags   <= go ? fault : ~poll_flags;
      poll_reading <= go ? value : ~poll_reading;
    end
endmodule

// ===== sim/bank_monitor.sv
// assertions on the ports of the smbus master register bank
module bank_monitor (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  input wire        clk_en,
  // apb side
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  // poll results
  input wire        poll_done,
  input wire [2:0]  poll_dev_idx,
  // controls and interrupt
  input wire        master_poll_enable,
  input wire [3:0]  polled_temp_hysteresis,
  input wire [2:0]  cur_format_mode,
  input wire        remote1_to_modules_01,
  input wire        remote2_to_modules_23,
  input wire        module_temp_from_hub,
  input wire        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed write to the master configuration word
  sequence cfg_wr;
    psel && penable && pready && pwrite && paddr == 12'h2d4;
  endsequence
  a_enable_follows: assert property (
    cfg_wr |=> ##1 master_poll_enable == $past(pwdata[0], 2)) else $error("enable wrong");
  // two quiet bus cycles rule out a config write still on its way
  a_poll_off: assert property (
    !psel && !$past(psel) && !master_poll_enable && !irq |=> !irq) else $error("poll not idle");
  a_hys_follows: assert property (
    cfg_wr |=> ##1 polled_temp_hysteresis == $past(pwdata[4:1], 2)) else $error("hyst wrong");
  a_remote_sel: assert property (
    cfg_wr |=> ##1 {remote2_to_modules_23, remote1_to_modules_01} ==
      ($past(pwdata[6:5], 2) & ~{2{$past(pwdata[7], 2)}})) else $error("remote copy wrong");
  a_hub_source: assert property (
    cfg_wr |=> ##1 module_temp_from_hub == $past(pwdata[7], 2)) else $error("hub source wrong");
  a_block_only: assert property (
    cur_format_mode == 3'h3 && $past(clk_en) |-> $past(poll_dev_idx) < 3'h4)
    else $error("block mode on 4-7");
  a_literal_only: assert property (
    cur_format_mode == 3'h4 && $past(clk_en) |-> $past(poll_dev_idx) > 3'h4)
    else $error("literal on 0-4");
  a_irq_cause: assert property (
    $rose(irq) |-> $past(poll_done) || $past(psel, 2)) else $error("irq without cause");
  c_cfg: cover property (cfg_wr);
  c_irq: cover property ($rose(irq));
  c_lit: cover property (cur_format_mode == 3'h4);
endmodule

bind smbus_master_cfg_status_regs bank_monitor i_mon (.*);

// ===== sim/testbench.sv
// self-checking bench of the smbus master register bank against an integer model
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        go = 1'b0, er, chk_mode = 1'b0, ce = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, seed = 32'd36659;
  logic [2:0]  gidx = 3'h0, gflt = 3'h0, last_idx;
  logic [7:0]  gval = 8'h00, ghi = 8'h00, glo = 8'h00;
  wire  [31:0] prdata;
  wire  [7:0]  rdg, hil, lol;
  wire  [3:0]  hys;
  wire  [2:0]  didx, flg, mode;
  wire         pready, pslverr, done, pen, r1, r2, hub, irq, cpe;
  int          n_errors = 0, check_count = 0, cyc = 0, en = 0, f03 = 3, f47 = 0;
  int          pe = 0, nm = 0, im = 0, ist = 0, h, x, st[4] = '{0, 0, 0, 0};

  smbus_master_cfg_status_regs i_smbus_master_cfg_status_regs (
    .pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .poll_done(done), .poll_dev_idx(didx), .poll_no_ack(flg[0]),
    .poll_pec_fail(flg[1]), .poll_timeout(flg[2]), .poll_reading(rdg), .high_limit(hil),
    .low_limit(lol), .master_poll_enable(pen), .polled_temp_hysteresis(hys),
    .cur_format_mode(mode), .cur_pec_enable(cpe), .remote1_to_modules_01(r1),
    .remote2_to_modules_23(r2), .module_temp_from_hub(hub), .irq(irq));
  sensor_poll_model i_sensor_poll_model (
    .pclk(pclk), .presetn(presetn), .go(go), .idx(gidx), .fault(gflt), .value(gval),
    .hi_set(ghi), .lo_set(glo),
    .poll_done(done), .poll_dev_idx(didx), .poll_flags(flg), .poll_reading(rdg),
    .high_limit(hil), .low_limit(lol));

  // free running clock and a hang guard
  always #4 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      complete_run();
    end
  end
  // one cycle after each result the bank must show that device's decoded format
  always @(posedge pclk)
  begin
    if (chk_mode)
    begin
      `CHK(mode, mode_of(last_idx))
      `CHK(cpe, pe[last_idx])
    end
    chk_mode <= done & ce;
    last_idx <= didx;
  end

  function automatic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic [2:0] mode_of(input [2:0] d);
    int c;
    c = d < 4 ? (f03 >> 2 * d) & 3 : (f47 >> 2 * (d - 4)) & 3;
    if (c < 3)
      return c;
    return d < 4 ? 3'h3 : (d == 4 ? 3'h5 : 3'h4);
  endfunction
  // one apb transfer, held until pready is sampled high
  task automatic apb(input bit w, input [9:0] i, input [7:0] d);
    int n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {i, 2'b00};
    pwdata <= (rnd() << 8) | d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n == 20)
    begin
      n_errors++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input [9:0] i, input [7:0] e);
    apb(0, i, 8'h00);
    `CHK({er, rd}, {25'h0, e})
  endtask
  // one poll result, then the model's expected sticky bits and interrupt
  task automatic poll(input int i, input int f, input int v);
    int b;
    int p;
    int l;
    int r;
    logic [7:0] hv, lv;
    b = 1 << i;
    r = rnd();
    hv = r[7:0];
    lv = r[15:8];
    @(posedge pclk);
    ghi  <= hv;
    glo  <= lv;
    go   <= 1'b1;
    gidx <= i[2:0];
    gflt <= f[2:0];
    gval <= v[7:0];
    @(posedge pclk);
    go <= 1'b0;
    repeat (3) @(posedge pclk);
    l = mode_of(i[2:0]) == 3'h0 ? ($signed(v[7:0]) > $signed(hv) || $signed(v[7:0]) < $signed(lv))
                                : (v[7:0] > hv || v[7:0] < lv);
    p = f[1] && !f[0] && (pe & b) != 0;
    l = l && !f[0] && !f[2] && !p;
    if (en)
    begin
      st[0] |= f[0] ? b : 0;
      st[1] |= p ? b : 0;
      st[2] |= f[2] ? b : 0;
      st[3] |= l ? b : 0;
      ist |= (f[0] && (nm & b) == 0 ? 1 : 0) | p << 1 | (f[2] ? 4 : 0) | l << 3;
    end
    `CHK(irq, (ist & im) != 0)
  endtask
  task automatic complete_run();
    $display("errors %0d, checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rchk(10'hb2, 8'h03);
    rchk(10'hb3, 8'h00);
    rchk(10'hb5, 8'h08);
    `CHK({hys, pen, hub, r2, r1}, 8'h40)
    for (int s = 0; s < 4; s++) rchk(10'hb6 + s, 8'h00);
    apb(0, 10'hb4, 8'h00);
    `CHK({er, rd}, 33'h100000000)
    apb(1, 10'hb6, 8'hff);
    poll(1, 1, 8'h60);
    rchk(10'hb6, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      f03 = c * 8'h55;
      f47 = c == 3 ? 8'hfe : c * 8'h55;
      apb(1, 10'hb2, f03);
      apb(1, 10'hb3, f47);
      rchk(10'hb3, f47);
      for (int d = 0; d < 8; d++) poll(d, 0, 8'h30);
    end
    for (int k = 0; k < 8; k++)
    begin
      h = rnd() & 15;
      apb(1, 10'hb5, {k[2:0], h[3:0], 1'b1});
      repeat (2) @(posedge pclk);
      `CHK({hub, r2, r1, hys, pen}, {k[2], k[1:0] & ~{2{k[2]}}, h[3:0], 1'b1})
    end
    en = 1;
    pe = rnd() & 255;
    nm = rnd() & 255;
    im = rnd() & 15;
    f03 = rnd() & 255;
    f47 = (rnd() & 8'hfc) | (rnd() % 3);
    apb(1, 10'hb1, pe);
    apb(1, 10'hbc, nm);
    apb(1, 10'hd1, im);
    apb(1, 10'hb2, f03);
    apb(1, 10'hb3, f47);
    repeat (4)
    begin
      for (int j = 0; j < 12; j++) poll(rnd() % 8, rnd() % 8, rnd() % 256);
      rchk(10'hd0, ist);
      for (int s = 0; s < 4; s++)
      begin
        rchk(10'hb6 + s, st[s]);
        st[s] = 0;
        rchk(10'hb6 + s, 8'h00);
      end
      x = rnd() & 15;
      apb(1, 10'hd0, x);
      ist &= ~x;
      repeat (2) @(posedge pclk);
      `CHK(irq, (ist & im) != 0)
    end
    // a result that arrives while the clock enable is low must leave all four status registers alone
    @(posedge pclk);
    ce   <= 1'b0;
    go   <= 1'b1;
    gidx <= 3'h3;
    gflt <= 3'h7;
    @(posedge pclk);
    go <= 1'b0;
    repeat (2) @(posedge pclk);
    ce <= 1'b1;
    for (int s = 0; s < 4; s++) rchk(10'hb6 + s, 8'h00);
    complete_run();
  end
endmodule
